// *** bench/clock_enable_gen.sv ***
// Far-side model: free-running write and read clock-edge pulses
`timescale 1ns/10ps
`default_nettype none
module clock_enable_gen (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] wrPeriod,
  input  wire logic [3:0] rdPeriod,
  output var  logic       wrClkEn,
  output var  logic       rdClkEn
);
  logic [3:0] wrCnt_reg;
  logic [3:0] rdCnt_reg;

  // Unrelated periods and start phases keep the two sides drifting
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrCnt_reg <= 4'h0;
      rdCnt_reg <= 4'h1;
      wrClkEn   <= 1'h0;
      rdClkEn   <= 1'h0;
    end else begin
      wrCnt_reg <= (wrCnt_reg >= wrPeriod - 4'h1) ? 4'h0 : wrCnt_reg + 4'h1;
      rdCnt_reg <= (rdCnt_reg >= rdPeriod - 4'h1) ? 4'h0 : rdCnt_reg + 4'h1;
      wrClkEn   <= (wrCnt_reg == 4'h0);
      rdClkEn   <= (rdCnt_reg == 4'h0);
    end
  end
endmodule : clock_enable_gen
`default_nettype wire

// *** bench/tb_fifo_flag_core.sv ***
// Self-checking bench for the FIFO flag and mode core
`timescale 1ns/10ps
`default_nettype none
module tb_fifo_flag_core;
  logic        sys_clk;
  logic        rst_b;
  logic        writeReq;
  logic [17:0] writeData;
  logic        readReq;
  logic        outputEnableN;
  logic        offsetAccessSelN;
  logic        readChainOutN;
  logic        writeChainOutN;
  logic [2:0]  strap;
  logic        wrClkEn;
  logic        rdClkEn;
  logic [17:0] readDataOut;
  logic        readDataOe;
  logic        emptyIndicatorN;
  logic        fullIndicatorN;
  logic        spaceAvailN;
  logic        almostEmptyN;
  logic        almostFullN;
  logic        halfFullN;
  logic        fallThroughMode;
  int          n_errors;
  int          checked;

  clock_enable_gen partner (.sys_clk(sys_clk), .rst_b(rst_b), .wrPeriod(4'h2),
    .rdPeriod(4'h3), .wrClkEn(wrClkEn), .rdClkEn(rdClkEn));

  fifo_flag_core uut (.sys_clk(sys_clk), .rst_b(rst_b), .wrClkEn(wrClkEn),
    .rdClkEn(rdClkEn), .writeReq(writeReq), .writeData(writeData), .readReq(readReq),
    .offsetAccessSelN(offsetAccessSelN), .outputEnableN(outputEnableN),
    .firstLoadStrap(strap[2]),
    .readChainInN(strap[1]), .writeChainInN(strap[0]), .readDataOut(readDataOut),
    .readDataOe(readDataOe), .emptyIndicatorN(emptyIndicatorN),
    .fullIndicatorN(fullIndicatorN), .spaceAvailN(spaceAvailN),
    .almostEmptyN(almostEmptyN), .almostFullN(almostFullN), .halfFullN(halfFullN),
    .readChainOutN(readChainOutN), .writeChainOutN(writeChainOutN),
    .fallThroughMode(fallThroughMode));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Straps are set under reset and held, except where t_fall_through_mode changes them without a reset
  task automatic do_reset(input logic [2:0] s);
    rst_b <= 1'b0;
    strap <= s;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset

  task automatic wr(input logic [17:0] d);
    writeReq  <= 1'b1;
    writeData <= d;
    do @(posedge sys_clk); while (wrClkEn !== 1'b1);
    writeReq <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(output logic [17:0] q);
    readReq <= 1'b1;
    do @(posedge sys_clk); while (rdClkEn !== 1'b1);
    readReq <= 1'b0;
    @(posedge sys_clk);
    q = readDataOut;
  endtask : rd

  task automatic wait_empty(input logic lvl, input int bound);
    int k;
    k = 0;
    while (emptyIndicatorN !== lvl && k < bound) begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wait_empty

  task automatic t_reset_oe();
    do_reset(3'h0);
    chk(emptyIndicatorN, 1'b0);
    chk(fullIndicatorN, 1'b1);
    outputEnableN <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(readDataOe, 1'b1);
    chk(readDataOut, 18'h00000);
    outputEnableN <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(readDataOe, 1'b0);
    outputEnableN <= 1'b0;
  endtask : t_reset_oe

  // First word through every standard strap except 111, double buffering given a longer bound
  task automatic t_first_word();
    logic [2:0]  s [5] = '{3'h0, 3'h3, 3'h4, 3'h2, 3'h6};
    logic [17:0] q;
    for (int i = 0; i < 5; i++) begin
      do_reset(s[i]);
      wr(18'h2A5A5);
      wait_empty(1'b1, (i > 2) ? 14 : 10);
      chk(emptyIndicatorN, 1'b1);
      rd(q);
      chk(q, 18'h2A5A5);
      chk(emptyIndicatorN, 1'b0);
    end
  endtask : t_first_word

  // Single strap and chain strap; chain mode drops half-full and pulses the chain outputs
  task automatic t_full(input logic [2:0] st);
    logic [17:0] q;
    do_reset(st);
    for (int i = 1; i <= 257; i++) begin
      wr(18'(i));
      if (i == 224) chk(almostFullN, 1'b1);
      if (i == 225) chk(almostFullN, 1'b0);
      if (i == 255) chk(fullIndicatorN, 1'b1);
      if (i == 256) chk(fullIndicatorN, 1'b0);
      if (i == 256) chk(halfFullN, (st == 3'h3));
      if (i == 256) chk(writeChainOutN, (st != 3'h3));
    end
    for (int i = 1; i <= 256; i++) begin
      rd(q);
      chk(q, 18'(i));
      if (i == 8) chk(fullIndicatorN, 1'b1);
      if (i == 255) chk(readChainOutN, 1'b1);
      if (i == 256) chk(readChainOutN, (st != 3'h3));
    end
    chk(emptyIndicatorN, 1'b0);
  endtask : t_full

  // Offsets load empty then full, read back in order, then move the partial flags
  task automatic t_offsets();
    logic [17:0] q;
    do_reset(3'h0);
    offsetAccessSelN <= 1'b0;
    wr(18'h00010);
    wr(18'h000E0);
    rd(q);
    chk(q, 18'h00010);
    rd(q);
    chk(q, 18'h000E0);
    offsetAccessSelN <= 1'b1;
    chk(emptyIndicatorN, 1'b0);
    for (int i = 1; i <= 32; i++) begin
      wr(18'(i));
      if (i == 16) chk(almostEmptyN, 1'b0);
      if (i == 17) chk(almostEmptyN, 1'b1);
      if (i == 31) chk(almostFullN, 1'b1);
      if (i == 32) chk(almostFullN, 1'b0);
    end
  endtask : t_offsets

  task automatic t_fall_through_mode();
    logic [17:0] q;
    do_reset(3'h1);
    chk(fallThroughMode, 1'b1);
    chk(emptyIndicatorN, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk(spaceAvailN, 1'b0);
    wr(18'h1F00F);
    wait_empty(1'b0, 16);
    chk(emptyIndicatorN, 1'b0);
    chk(readDataOut, 18'h1F00F);
    rd(q);
    chk(emptyIndicatorN, 1'b1);
    chk(readDataOut, 18'h1F00F);
    offsetAccessSelN <= 1'b0;
    rd(q);
    chk(readDataOut, 18'h1F00F);
    offsetAccessSelN <= 1'b1;
    for (int i = 1; i <= 257; i++) begin
      wr(18'(i));
      if (i == 256) chk(spaceAvailN, 1'b0);
      if (i == 257) chk(spaceAvailN, 1'b1);
    end
    strap <= 3'h0;
    repeat (3) @(posedge sys_clk);
    chk(fallThroughMode, 1'b1);
  endtask : t_fall_through_mode

  task automatic t_modes();
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      chk(fallThroughMode, (s == 1 || s == 5));
    end
  endtask : t_modes

  initial begin
    n_errors      = 0;
    checked       = 0;
    rst_b         = 1'b0;
    writeReq      = 1'b0;
    writeData     = 18'h00000;
    readReq       = 1'b0;
    outputEnableN = 1'b1;
    offsetAccessSelN = 1'b1;
    strap         = 3'h0;
    t_reset_oe();
    t_first_word();
    t_full(3'h0);
    t_full(3'h3);
    t_offsets();
    t_fall_through_mode();
    t_modes();
    results();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    results();
  end
endmodule : tb_fifo_flag_core
`default_nettype wire

// *** design/fifo_flag_consts.svh ***
// Constants for the dual-clock FIFO flag and mode logic
`ifndef FIFO_FLAG_CONSTS_SVH
`define FIFO_FLAG_CONSTS_SVH

`define FIFO_DEPTH          256
`define FIFO_DATA_WIDTH     18
`define DEFAULT_EMPTY_OFS   31
`define DEFAULT_FULL_OFS    31

`define STRAP_STD_SGL_A     3'h0
`define STRAP_STD_SGL_B     3'h3
`define STRAP_STD_SGL_C     3'h4
`define STRAP_STD_SGL_D     3'h7
`define STRAP_STD_DBL_A     3'h2
`define STRAP_STD_DBL_B     3'h6
`define STRAP_FALL_THROUGH_MODE_A        3'h1
`define STRAP_FALL_THROUGH_MODE_B        3'h5

`define SYS_CLK_PERIOD_NS   5
`define MIN_CLOCK_SKEW_NS   10
`define SKEW_CYCLES         ((`MIN_CLOCK_SKEW_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SKEW_AGE_W          4

`define RST_EMPTY_N         1'h0
`define RST_FULL_N          1'h1
`define RST_SPACE_N         1'h1
`define RST_ALMOST_EMPTY_N  1'h0
`define RST_ALMOST_FULL_N   1'h1
`define RST_HALF_FULL_N     1'h1

`endif

// *** design/fifo_flag_core.sv ***
// FIFO core with mode straps, full/empty, partial and half-full flags
//
`include "fifo_flag_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Pulse read chain out on last-location read
// - Read data output is 18 bits
// - Six strap combinations mean single, half-full
// - Free-running clocks, independent or coincident
// - Outputs low with enable, off without
// - Fall-through space flag goes low on write edge
// - Straps 000/011/100/111 give single-buffered flags
// - Single full flag lags read by skew
// - Single empty flag lags write by skew
// - First word readable cycle after empty clears
// - First-word latency one or two read clocks
// - Straps 010/110 give double-buffered flags
// - Double empty flag one extra read clock
// - Straps 001/101 give fall-through output
// - Output ready two read clocks after write
// - Space flag back one write clock after read (code: two write clocks, rdSyncW then irN)
// - Fall-through depth is array plus one
// - Async almost-empty: read sets, write clears
// - Async almost-full: write sets, read clears
// - Sync almost-empty changes on read edges only
// - Sync almost-full changes on write edges only
// - Offsets writable always, readable in standard only
// - Full blocks writes, empty blocks reads
// - Output ready clears on true read, holds word
module fifo_flag_core #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int DW    = `FIFO_DATA_WIDTH
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic          wrClkEn,
  input  wire logic          rdClkEn,
  input  wire logic          writeReq,
  input  wire logic [DW-1:0] writeData,
  input  wire logic          readReq,
  input  wire logic          offsetAccessSelN,
  input  wire logic          outputEnableN,
  input  wire logic          firstLoadStrap,
  input  wire logic          readChainInN,
  input  wire logic          writeChainInN,
  output wire logic [DW-1:0] readDataOut,
  output wire logic          readDataOe,
  output wire logic          emptyIndicatorN,
  output wire logic          fullIndicatorN,
  output wire logic          spaceAvailN,
  output wire logic          almostEmptyN,
  output wire logic          almostFullN,
  output wire logic          halfFullN,
  output wire logic          readChainOutN,
  output wire logic          writeChainOutN,
  output wire logic          fallThroughMode
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_A  = AW'(DEPTH - 1);
  localparam logic [`SKEW_AGE_W-1:0] SKEW_P = `SKEW_AGE_W'(`SKEW_CYCLES);

  // Pointer as seen from the opposite side
  typedef struct packed {
    logic [PW-1:0]          pend;
    logic [PW-1:0]          vis;
    logic [`SKEW_AGE_W-1:0] age;
  } trk_t;

  typedef struct packed {
    logic                  modeValid;
    fifo_flag_pkg::mode_t  mode;
    logic [PW-1:0]         wrPtr;
    logic [PW-1:0]         rdPtr;
    logic [PW-1:0]         rdSyncW;
    logic [PW-1:0]         wrSyncR;
    trk_t                  rdTrk;
    trk_t                  wrTrk;
    logic                  outValid;
    logic [DW-1:0]         data;
    logic                  oe;
    logic                  emptyN;
    logic                  fullN;
    logic                  irN;
    logic                  aeN;
    logic                  afN;
    logic                  hfN;
    logic                  rxoN;
    logic                  wxoN;
    logic                  rdTok;
    logic                  wrTok;
    logic                  ofsWrSel;
    logic                  ofsRdSel;
    logic [AW-1:0]         emptyOfs;
    logic [AW-1:0]         fullOfs;
  } st_t;

  function automatic st_t rst_state();
    st_t r;
    r          = '0;
    r.emptyN   = `RST_EMPTY_N;
    r.fullN    = `RST_FULL_N;
    r.irN      = `RST_SPACE_N;
    r.aeN      = `RST_ALMOST_EMPTY_N;
    r.afN      = `RST_ALMOST_FULL_N;
    r.hfN      = `RST_HALF_FULL_N;
    r.rxoN     = 1'h1;
    r.wxoN     = 1'h1;
    r.emptyOfs = AW'(`DEFAULT_EMPTY_OFS);
    r.fullOfs  = AW'(`DEFAULT_FULL_OFS);
    return r;
  endfunction : rst_state

  localparam st_t RST_ST = rst_state();

  // A change becomes visible only after it stood for the skew time
  function automatic trk_t trk_step(input trk_t t, input logic [PW-1:0] p);
    trk_t r;
    r = t;
    if (t.age == SKEW_P) begin
      r.vis = t.pend;
      if (p != t.pend) begin
        r.pend = p;
        r.age  = '0;
      end
    end else begin
      r.age = t.age + 1'b1;
    end
    return r;
  endfunction : trk_step

  st_t                  s;
  st_t                  n;
  fifo_flag_pkg::mode_t md;
  fifo_flag_pkg::strap_t strap;
  logic [DW-1:0]        mem [DEPTH];
  logic [PW-1:0]        wVis;
  logic [PW-1:0]        rVis;
  logic [PW-1:0]        memCntW;
  logic [PW-1:0]        memCntR;
  logic [PW-1:0]        newCntW;
  logic [PW-1:0]        newCntR;
  logic [PW-1:0]        effW;
  logic [PW-1:0]        effR;
  logic [PW-1:0]        aeThr;
  logic [PW-1:0]        afThr;
  logic                 wrAcc;
  logic                 stdRd;
  logic                 take;
  logic                 load;
  logic                 rdFromMem;
  logic                 ovNext;
  logic [DW-1:0]        memWord;

  assign strap   = '{firstLoad: firstLoadStrap, readChain: readChainInN, writeChain: writeChainInN};
  assign md      = s.mode;
  assign memWord = mem[s.rdPtr[AW-1:0]];

  always_comb begin
    n = s;
    // Double-buffered and fall-through modes add one register stage
    wVis = (md.dbl || md.fall_through_mode) ? s.rdSyncW : s.rdTrk.vis;
    rVis = (md.dbl || md.fall_through_mode) ? s.wrSyncR : s.wrTrk.vis;
    memCntW = s.wrPtr - wVis;
    memCntR = rVis - s.rdPtr;
    aeThr = {1'b0, s.emptyOfs} + PW'(md.fall_through_mode);
    afThr = DEPTH_P + PW'(md.fall_through_mode) - {1'b0, s.fullOfs};
    wrAcc = s.modeValid && wrClkEn && writeReq && offsetAccessSelN
            && (memCntW != DEPTH_P) && (!md.daisy || s.wrTok);
    stdRd = !md.fall_through_mode && readReq && offsetAccessSelN && (memCntR != '0)
            && (!md.daisy || s.rdTok);
    take = md.fall_through_mode && readReq && offsetAccessSelN && s.outValid;
    load = md.fall_through_mode && (memCntR != '0) && (!s.outValid || take)
           && (!md.daisy || s.rdTok);
    rdFromMem = s.modeValid && rdClkEn && (stdRd || load);
    ovNext = load ? 1'b1 : (take ? 1'b0 : s.outValid);
    newCntW = memCntW + PW'(wrAcc);
    newCntR = memCntR - PW'(rdFromMem);
    effW = newCntW + PW'(md.fall_through_mode && (newCntW != '0));
    effR = newCntR + PW'(md.fall_through_mode && ovNext);
    n.rdTrk = trk_step(s.rdTrk, s.rdPtr);
    n.wrTrk = trk_step(s.wrTrk, s.wrPtr);
    n.oe = !outputEnableN;
    n.rxoN = 1'b1;
    n.wxoN = 1'b1;
    if (!s.modeValid) begin
      // Straps are static, so the first edge after release catches them
      n.modeValid = 1'b1;
      n.mode = fifo_flag_pkg::decode_mode(strap);
      n.emptyN = n.mode.fall_through_mode;
      n.rdTok = !firstLoadStrap;
      n.wrTok = !firstLoadStrap;
    end else begin
      if (wrClkEn) begin
        n.rdSyncW = s.rdTrk.vis;
        if (writeReq && !offsetAccessSelN) begin
          // Offset registers load empty first, then full
          if (s.ofsWrSel) begin
            n.fullOfs = writeData[AW-1:0];
          end else begin
            n.emptyOfs = writeData[AW-1:0];
          end
          n.ofsWrSel = !s.ofsWrSel;
        end
        if (wrAcc) begin
          n.wrPtr = s.wrPtr + 1'b1;
          if (md.daisy && (s.wrPtr[AW-1:0] == LAST_A)) begin
            n.wxoN  = 1'b0;
            n.wrTok = 1'b0;
          end
        end
        if (md.fall_through_mode) begin
          n.irN = (newCntW == DEPTH_P);
        end else begin
          n.fullN = (newCntW != DEPTH_P);
        end
        // Only a real transfer moves an async flag; the lagging far pointer would undo it
        if (md.syncPartial) begin
          n.afN = !(effW >= afThr);
        end else if (wrAcc && (effW >= afThr)) begin
          n.afN = 1'b0;
        end
        if (!md.syncPartial && wrAcc && (effW > aeThr)) begin
          n.aeN = 1'b1;
        end
        if (md.single && wrAcc && (newCntW > HALF_P)) begin
          n.hfN = 1'b0;
        end
      end
      if (rdClkEn) begin
        n.wrSyncR = s.wrTrk.vis;
        if (rdFromMem) begin
          n.data  = memWord;
          n.rdPtr = s.rdPtr + 1'b1;
          if (md.daisy && (s.rdPtr[AW-1:0] == LAST_A)) begin
            n.rxoN  = 1'b0;
            n.rdTok = 1'b0;
          end
        end else if (!md.fall_through_mode && readReq && !offsetAccessSelN) begin
          n.data     = s.ofsRdSel ? DW'(s.fullOfs) : DW'(s.emptyOfs);
          n.ofsRdSel = !s.ofsRdSel;
        end
        n.outValid = md.fall_through_mode && ovNext;
        n.emptyN = md.fall_through_mode ? !ovNext : (newCntR != '0);
        if (md.syncPartial) begin
          n.aeN = !(effR <= aeThr);
        end else if ((rdFromMem || take) && (effR <= aeThr)) begin
          n.aeN = 1'b0;
        end
        if (!md.syncPartial && (rdFromMem || take) && (effR < afThr)) begin
          n.afN = 1'b1;
        end
        if (md.single && (rdFromMem || take) && (newCntR <= HALF_P)) begin
          n.hfN = 1'b1;
        end
      end
      // Incoming token wins over a same-cycle hand-off
      if (md.daisy && !writeChainInN) begin
        n.wrTok = 1'b1;
      end
      if (md.daisy && !readChainInN) begin
        n.rdTok = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RST_ST;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wrAcc) begin
      mem[s.wrPtr[AW-1:0]] <= writeData;
    end
  end

  assign readDataOut     = s.data;
  assign readDataOe      = s.oe;
  assign emptyIndicatorN = s.emptyN;
  assign fullIndicatorN  = s.fullN;
  assign spaceAvailN     = s.irN;
  assign almostEmptyN    = s.aeN;
  assign almostFullN     = s.afN;
  assign halfFullN       = s.hfN;
  assign readChainOutN   = s.rxoN;
  assign writeChainOutN  = s.wxoN;
  assign fallThroughMode = s.mode.fall_through_mode;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_full_write_block: assert property (
    s.modeValid && wrClkEn && (memCntW == DEPTH_P) |=> s.wrPtr == $past(s.wrPtr))
    else $error("write taken while full");

  a_empty_read_block: assert property (
    s.modeValid && rdClkEn && !md.fall_through_mode && (memCntR == '0) |=> $stable(s.rdPtr))
    else $error("read taken while empty");

  a_chain_pulse_len: assert property (
    !s.rxoN |=> s.rxoN)
    else $error("read chain pulse longer than one cycle");

  a_chain_pulse_src: assert property (
    $fell(s.rxoN) |-> $past(rdFromMem) && ($past(s.rdPtr[AW-1:0]) == LAST_A))
    else $error("read chain pulse without last-location read");

  a_mode_static: assert property (
    s.modeValid |=> $stable(s.mode) && s.modeValid)
    else $error("mode changed after capture");

  a_oe_follow: assert property (
    s.modeValid |=> s.oe == !$past(outputEnableN))
    else $error("output enable does not follow its input");

  a_or_hold_word: assert property (
    s.modeValid && md.fall_through_mode && s.emptyN && !(rdClkEn && load) |=> $stable(s.data))
    else $error("output word changed while output not ready");

  a_half_daisy: assert property (
    s.modeValid && !md.single |-> s.hfN)
    else $error("half-full asserted in chain mode");

  a_sync_ae_edge: assert property (
    s.modeValid && md.syncPartial && !rdClkEn |=> $stable(s.aeN))
    else $error("sync almost-empty moved off a read edge");

  a_sync_af_edge: assert property (
    s.modeValid && md.syncPartial && !wrClkEn |=> $stable(s.afN))
    else $error("sync almost-full moved off a write edge");

  a_std_full_set: assert property (
    s.modeValid && !md.fall_through_mode && wrAcc && (newCntW == DEPTH_P) |=> !s.fullN)
    else $error("full flag missed at depth");

  c_fall_through_mode_first_word: cover property (md.fall_through_mode && $fell(s.emptyN));
  c_std_full: cover property (!md.fall_through_mode && $fell(s.fullN));
  c_chain_pulse: cover property ($fell(s.rxoN));
  c_ir_full: cover property (md.fall_through_mode && $rose(s.irN));

endmodule : fifo_flag_core

`default_nettype wire

// *** design/fifo_flag_pkg.sv ***
// Types and strap decoding for the dual-clock FIFO flag logic
`default_nettype none
`include "fifo_flag_consts.svh"

package fifo_flag_pkg;

  typedef struct packed {
    logic firstLoad;
    logic readChain;
    logic writeChain;
  } strap_t;

  typedef struct packed {
    logic fall_through_mode;
    logic dbl;
    logic syncPartial;
    logic single;
    logic daisy;
  } mode_t;

  function automatic mode_t decode_mode(input strap_t st);
    mode_t m;
    m = '0;
    m.fall_through_mode        = (st == `STRAP_FALL_THROUGH_MODE_A) || (st == `STRAP_FALL_THROUGH_MODE_B);
    m.dbl         = (st == `STRAP_STD_DBL_A) || (st == `STRAP_STD_DBL_B);
    m.syncPartial = (st == `STRAP_STD_SGL_C) || (st == `STRAP_FALL_THROUGH_MODE_B) || (st == `STRAP_STD_DBL_B);
    m.daisy       = (st == `STRAP_STD_SGL_B) || (st == `STRAP_STD_SGL_D);
    m.single      = !m.daisy;
    return m;
  endfunction : decode_mode

endpackage : fifo_flag_pkg

`default_nettype wire
